// >>> pkg/dpsc_pkg.sv
// Purpose: Shared constants and types for the dual pot serial control block.
// Assumes: Two 8-bit wiper codes plus one stack-select bit in one shift word.
// Notes: Field positions count from the end that leaves on the cascade output.
`default_nettype none
package dpsc_pkg;

    // Shift word layout
    localparam int WIPER_W = 8;
    localparam int SHIFT_W = 2 * WIPER_W + 1;
    localparam int STACK_POS = 0;
    localparam int POT1_MSB_POS = 1;
    localparam int POT1_LSB_POS = 8;
    localparam int POT0_MSB_POS = 9;
    localparam int POT0_LSB_POS = 16;

    // Bits per device in one chain frame
    localparam int FRAME_BITS = 17;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] LAST_PHASE = COUNT_W'(FRAME_BITS - 1);

    // Reset values
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 17'h0_0000;
    localparam logic [WIPER_W-1:0] WIPER_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h00;
    localparam int SYNC_W = 2;

    typedef enum logic [1:0] {
        DPSC_IDLE = 2'b00,
        DPSC_ACTIVE = 2'b01,
        DPSC_APPLY = 2'b11
    } dpsc_state_t;

endpackage : dpsc_pkg
`default_nettype wire

// >>> design/dpsc_sync.sv
// Purpose: Two-stage level synchroniser into the system clock domain.
// Assumes: Inputs are levels that stay put for several destination cycles.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module dpsc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    always_comb begin
        next_stage1 = async_in;
        next_stage2 = stage1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_out = stage2;

endmodule : dpsc_sync
`default_nettype wire

// >>> design/dpsc_top.sv
// Purpose: Serial control of a dual 256-step potentiometer with cascade output.
// Assumes: Port enable and data meet setup and hold around the serial clock.
// Notes: Serial clock may stop outside frames; wipers update in clk_in domain.
//
// Function
// - Two wipers, each set by 8-bit code
// - Port ignores clock and data when disabled
// - Transaction begins only on enable rising
// - One data bit shifted per rising clock
// - Seventeen-bit shift word, bit zero stack
// - Bits one to eight: pot one, MSB first
// - Bits nine to sixteen: pot zero, MSB first
// - Wipers load only when enable falls
// - Wiper value after power-up is unspecified; here reset loads WIPER_RESET (zero)
// - Stacked output follows stack-select bit
// - Cascade shows bit leaving, stack first
// - Cascade holds stack bit while idle
// - Readback feeds cascade back into input
// - Full circular shift restores original values
`timescale 1ns/1ns
`default_nettype none
module dpsc_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic serial_clk_in,
    input wire logic port_enable_in,
    input wire logic serial_data_in,
    output logic [dpsc_pkg::WIPER_W-1:0] pot0_wiper_out,
    output logic [dpsc_pkg::WIPER_W-1:0] pot1_wiper_out,
    output logic stack_select_out,
    output logic [dpsc_pkg::WIPER_W-1:0] stacked_wiper_out,
    output logic cascade_out,
    output logic port_active_out,
    output logic short_transfer_out
);
    import dpsc_pkg::*;

    // Pull one wiper code out of the shift word, MSB at the lower position
    function automatic logic [WIPER_W-1:0] field_code(
        input logic [SHIFT_W-1:0] word,
        input int msb_pos
    );
        logic [WIPER_W-1:0] code;
        code = WIPER_RESET;
        for (int k = 0; k < WIPER_W; k++) begin
            code[WIPER_W-1-k] = word[msb_pos+k];
        end
        return code;
    endfunction : field_code

    // Bit position within the current device frame
    function automatic logic [COUNT_W-1:0] phase_step(input logic [COUNT_W-1:0] phase);
        logic [COUNT_W-1:0] step;
        if (phase == LAST_PHASE) begin
            step = COUNT_RESET;
        end else begin
            step = COUNT_W'(phase + 1'b1);
        end
        return step;
    endfunction : phase_step

    // ------------------------------------------------------------------
    // Link domain: shift word clocked by the serial clock
    // ------------------------------------------------------------------
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] next_shift_reg;
    logic bit_toggle;
    logic next_bit_toggle;

    // Enable gates the shift, so a stray clock while disabled changes nothing
    always_comb begin
        next_shift_reg = shift_reg;
        next_bit_toggle = bit_toggle;
        if (port_enable_in) begin
            // New bit enters the far end, stack bit leaves first
            next_shift_reg = {serial_data_in, shift_reg[SHIFT_W-1:1]};
            next_bit_toggle = ~bit_toggle;
        end
    end

    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_reg <= SHIFT_RESET;
            bit_toggle <= 1'b0;
        end else begin
            shift_reg <= next_shift_reg;
            bit_toggle <= next_bit_toggle;
        end
    end

    // Straight from the word's exit flop; idle value is the stored stack bit
    assign cascade_out = shift_reg[STACK_POS];

    // ------------------------------------------------------------------
    // Crossing into the system domain
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] sync_bus;
    logic enable_sync;
    logic toggle_sync;
    // Only enable and the bit toggle cross here; the shift word is read
    // directly, as the gated enable has frozen it before APPLY sees the fall

    dpsc_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({bit_toggle, port_enable_in}),
        .sync_out(sync_bus)
    );

    assign enable_sync = sync_bus[0];
    assign toggle_sync = sync_bus[1];

    // ------------------------------------------------------------------
    // System domain: transaction tracking and wiper registers
    // ------------------------------------------------------------------
    dpsc_state_t state;
    dpsc_state_t next_state;
    logic enable_prev;
    logic next_enable_prev;
    logic toggle_prev;
    logic next_toggle_prev;
    logic [COUNT_W-1:0] bit_phase;
    logic [COUNT_W-1:0] next_bit_phase;
    logic [WIPER_W-1:0] next_pot0;
    logic [WIPER_W-1:0] next_pot1;
    logic next_stack;
    logic [WIPER_W-1:0] next_stacked;
    logic next_active;
    logic next_short;
    logic enable_rise;
    logic enable_fall;
    logic bit_seen;

    assign enable_rise = enable_sync & ~enable_prev;
    assign enable_fall = ~enable_sync & enable_prev;
    assign bit_seen = toggle_sync ^ toggle_prev;

    always_comb begin
        next_state = state;
        next_enable_prev = enable_sync;
        next_toggle_prev = toggle_sync;
        next_bit_phase = bit_phase;
        next_pot0 = pot0_wiper_out;
        next_pot1 = pot1_wiper_out;
        next_stack = stack_select_out;
        next_short = short_transfer_out;
        case (state)
            DPSC_IDLE: begin
                if (enable_rise) begin
                    next_state = DPSC_ACTIVE;
                    next_bit_phase = COUNT_RESET;
                end
            end
            DPSC_ACTIVE: begin
                if (bit_seen) begin
                    next_bit_phase = phase_step(bit_phase);
                end
                if (enable_fall) begin
                    next_state = DPSC_APPLY;
                end
            end
            DPSC_APPLY: begin
                // Link word is frozen here: enable is low, so the shift is gated
                next_pot0 = field_code(shift_reg, POT0_MSB_POS);
                next_pot1 = field_code(shift_reg, POT1_MSB_POS);
                next_stack = shift_reg[STACK_POS];
                // A partial frame still loads, but is flagged for software
                next_short = (bit_phase != COUNT_RESET);
                next_state = DPSC_IDLE;
            end
            default: begin
                next_state = DPSC_IDLE;
            end
        endcase
        next_stacked = next_stack ? next_pot1 : next_pot0;
        next_active = (next_state != DPSC_IDLE);
    end

    // Wipers only move from APPLY; all else holds them
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= DPSC_IDLE;
            enable_prev <= 1'b0;
            toggle_prev <= 1'b0;
            bit_phase <= COUNT_RESET;
            pot0_wiper_out <= WIPER_RESET;
            pot1_wiper_out <= WIPER_RESET;
            stack_select_out <= 1'b0;
            stacked_wiper_out <= WIPER_RESET;
            port_active_out <= 1'b0;
            short_transfer_out <= 1'b0;
        end else begin
            state <= next_state;
            enable_prev <= next_enable_prev;
            toggle_prev <= next_toggle_prev;
            bit_phase <= next_bit_phase;
            pot0_wiper_out <= next_pot0;
            pot1_wiper_out <= next_pot1;
            stack_select_out <= next_stack;
            stacked_wiper_out <= next_stacked;
            port_active_out <= next_active;
            short_transfer_out <= next_short;
        end
    end

    // ------------------------------------------------------------------
    // Checks, link domain
    // Serial clock may stop, so each check compares neighbouring edges only
    // ------------------------------------------------------------------
    shift_in_a: assert property (
        @(posedge serial_clk_in) disable iff (rst_in)
        port_enable_in |=> shift_reg[SHIFT_W-1] == $past(serial_data_in)
            && shift_reg[SHIFT_W-2:0] == $past(shift_reg[SHIFT_W-1:1])
    ) else $error("shift word did not take the serial bit");

    idle_hold_a: assert property (
        @(posedge serial_clk_in) disable iff (rst_in)
        !port_enable_in |=> $stable(shift_reg) && $stable(bit_toggle)
    ) else $error("shift word moved while the port was disabled");

    cascade_shift_a: assert property (
        @(posedge serial_clk_in) disable iff (rst_in)
        port_enable_in |=> cascade_out == $past(shift_reg[STACK_POS+1])
    ) else $error("cascade output did not advance to the next bit");

    toggle_flip_a: assert property (
        @(posedge serial_clk_in) disable iff (rst_in)
        port_enable_in |=> bit_toggle != $past(bit_toggle)
    ) else $error("bit toggle did not flip on an enabled serial edge");

    cascade_hold_a: assert property (
        @(posedge serial_clk_in) disable iff (rst_in)
        !port_enable_in |=> $stable(cascade_out)
    ) else $error("cascade output moved while the port was disabled");

    // ------------------------------------------------------------------
    // Checks, system domain
    // ------------------------------------------------------------------
    frame_start_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_IDLE && enable_rise |=> state == DPSC_ACTIVE && bit_phase == COUNT_RESET
    ) else $error("rising enable did not open a transaction");

    frame_end_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_ACTIVE && enable_fall |=> state == DPSC_APPLY ##1 state == DPSC_IDLE
    ) else $error("falling enable did not apply and return to idle");

    pot0_load_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_APPLY |=> pot0_wiper_out[WIPER_W-1] == $past(shift_reg[POT0_MSB_POS])
            && pot0_wiper_out[0] == $past(shift_reg[POT0_LSB_POS])
    ) else $error("pot zero code taken from the wrong bits");

    pot1_load_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_APPLY |=> pot1_wiper_out[WIPER_W-1] == $past(shift_reg[POT1_MSB_POS])
            && pot1_wiper_out[0] == $past(shift_reg[POT1_LSB_POS])
            && stack_select_out == $past(shift_reg[STACK_POS])
    ) else $error("pot one code or stack bit taken from the wrong bits");

    wiper_hold_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state != DPSC_APPLY |=> $stable(pot0_wiper_out) && $stable(pot1_wiper_out)
            && $stable(stack_select_out)
    ) else $error("wiper setting changed outside the apply step");

    stacked_mux_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        stacked_wiper_out == (stack_select_out ? pot1_wiper_out : pot0_wiper_out)
    ) else $error("stacked output does not follow the stack bit");

    phase_wrap_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_ACTIVE && bit_seen && !enable_fall && bit_phase == LAST_PHASE
            |=> bit_phase == COUNT_RESET
    ) else $error("bit phase did not wrap after a full frame");

    short_flag_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_APPLY |=> short_transfer_out == ($past(bit_phase) != COUNT_RESET)
    ) else $error("partial transfer flag disagrees with bit count");

    pot0_code_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_APPLY |=> pot0_wiper_out == $past({shift_reg[POT0_MSB_POS], shift_reg[POT0_MSB_POS+1],
            shift_reg[POT0_MSB_POS+2], shift_reg[POT0_MSB_POS+3], shift_reg[POT0_MSB_POS+4],
            shift_reg[POT0_MSB_POS+5], shift_reg[POT0_MSB_POS+6], shift_reg[POT0_LSB_POS]})
    ) else $error("pot zero code differs from its field in the shift word");

    pot1_code_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_APPLY |=> pot1_wiper_out == $past({shift_reg[POT1_MSB_POS], shift_reg[POT1_MSB_POS+1],
            shift_reg[POT1_MSB_POS+2], shift_reg[POT1_MSB_POS+3], shift_reg[POT1_MSB_POS+4],
            shift_reg[POT1_MSB_POS+5], shift_reg[POT1_MSB_POS+6], shift_reg[POT1_LSB_POS]})
    ) else $error("pot one code differs from its field in the shift word");

    active_flag_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        port_active_out == (state != DPSC_IDLE)
    ) else $error("active flag disagrees with the transaction state");

    apply_entry_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_APPLY |-> $past(state) == DPSC_ACTIVE && $past(enable_fall)
    ) else $error("apply step entered without a falling enable");

    short_hold_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state != DPSC_APPLY |=> $stable(short_transfer_out)
    ) else $error("partial transfer flag changed outside the apply step");

    phase_hold_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_ACTIVE && !bit_seen |=> $stable(bit_phase)
    ) else $error("bit phase moved with no serial bit seen");

    phase_step_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_ACTIVE && bit_seen && bit_phase != LAST_PHASE |=> bit_phase == COUNT_W'($past(bit_phase) + 1'b1)
    ) else $error("bit phase did not advance by one");

    stacked_hold_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state != DPSC_APPLY |=> $stable(stacked_wiper_out)
    ) else $error("stacked output changed outside the apply step");

    idle_stay_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == DPSC_IDLE && !enable_rise |=> state == DPSC_IDLE
    ) else $error("transaction opened without a rising enable");

endmodule : dpsc_top
`default_nettype wire

// >>> test/dpsc_host.sv
// Purpose: Host model driving the three-wire serial port of the pot block.
// Assumes: Bit period of 110 ns; the bit count crossing needs three system cycles.
// Notes: Serial clock stands still outside frames except in idle_clocks; data toggles when idle.
`timescale 1ns/1ns
`default_nettype none
module dpsc_host (
    output logic serial_clk_out,
    output logic port_enable_out,
    output logic data_out,
    output logic drive_out
);
    initial begin
        serial_clk_out = 1'h0;
        port_enable_out = 1'h0;
        data_out = 1'h0;
        drive_out = 1'h1;
    end

    // Low time before the rise covers the minimum inactive gap
    task automatic open_frame();
        #130 port_enable_out = 1'h1;
        #60;
    endtask : open_frame

    task automatic clock_bit(input logic b, input logic drive);
        drive_out = drive;
        data_out = b;
        #55 serial_clk_out = 1'h1;
        #55 serial_clk_out = 1'h0;
    endtask : clock_bit

    // Released line shows the inverse so a stale value never passes
    task automatic close_frame();
        #5 port_enable_out = 1'h0;
        drive_out = 1'h1;
        data_out = ~data_out;
    endtask : close_frame

    task automatic idle_clocks(input int n);
        repeat (n) begin
            data_out = ~data_out;
            #55 serial_clk_out = 1'h1;
            #55 serial_clk_out = 1'h0;
        end
    endtask : idle_clocks
endmodule : dpsc_host
`default_nettype wire

// >>> test/dpsc_top_tb.sv
// Purpose: Self-checking bench for the dual pot serial control block.
// Assumes: Wiper outputs reset to zero; apply ends when port_active_out drops.
// Notes: Readback loops cascade_out into the data input while the host floats it.
`timescale 1ns/1ns
`default_nettype none
module dpsc_top_tb;
    import dpsc_pkg::*;
    logic clk, rst, sclk, en, hdata, hdrive;
    logic [WIPER_W-1:0] pot0, pot1, stacked;
    logic stack, cascade, active, short_flag;
    logic [SHIFT_W-1:0] exp_word, app_word;
    int n_mismatch, samples_checked;
    wire logic sdata;
    assign sdata = hdrive ? hdata : cascade;

    always #10 clk = ~clk;

    dpsc_top u_dpsc_top (.clk_in(clk), .rst_in(rst), .serial_clk_in(sclk), .port_enable_in(en),
        .serial_data_in(sdata), .pot0_wiper_out(pot0), .pot1_wiper_out(pot1), .stack_select_out(stack),
        .stacked_wiper_out(stacked), .cascade_out(cascade), .port_active_out(active),
        .short_transfer_out(short_flag));
    dpsc_host u_dpsc_host (.serial_clk_out(sclk), .port_enable_out(en), .data_out(hdata), .drive_out(hdrive));

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] field(input logic [16:0] w, input int msb);
        logic [7:0] f;
        for (int i = 0; i < 8; i++) begin
            f[7-i] = w[msb+i];
        end
        return f;
    endfunction : field

    // Word bit i is the i-th bit sent
    function automatic logic [16:0] mk(input logic s, input logic [7:0] p1, input logic [7:0] p0);
        logic [16:0] w;
        w[0] = s;
        for (int i = 0; i < 8; i++) begin
            w[1+i] = p1[7-i];
            w[9+i] = p0[7-i];
        end
        return w;
    endfunction : mk

    task automatic check_applied(input logic exp_short);
        chk("pot0", field(app_word, POT0_MSB_POS), pot0);
        chk("pot1", field(app_word, POT1_MSB_POS), pot1);
        chk("stack", app_word[STACK_POS], stack);
        chk("stacked", app_word[0] ? field(app_word, 1) : field(app_word, 9), stacked);
        chk("cascade idle", app_word[0], cascade);
        chk("short", exp_short, short_flag);
    endtask : check_applied

    task automatic frame(input logic [33:0] bits, input int n, input logic drive, input logic exp_short);
        logic b;
        int k;
        u_dpsc_host.open_frame();
        for (int i = 0; i < n; i++) begin
            b = drive ? bits[i] : cascade;
            u_dpsc_host.clock_bit(b, drive);
            exp_word = {b, exp_word[16:1]};
            chk("cascade shift", exp_word[0], cascade);
        end
        chk("active", 1'h1, active);
        chk("pot0 held", field(app_word, 9), pot0);
        u_dpsc_host.close_frame();
        k = 0;
        while (active !== 1'h0 && k < 8) begin
            @(posedge clk);
            #2 k++;
        end
        if (k == 8) begin
            n_mismatch++;
            $display("BAD apply expected done seen timeout");
            final_report();
        end
        app_word = exp_word;
        check_applied(exp_short);
    endtask : frame

    task automatic t_write();
        frame(34'(mk(1'h0, 8'hA5, 8'h3C)), 17, 1'h1, 1'h0);
        frame(34'(mk(1'h1, 8'h0F, 8'hF0)), 17, 1'h1, 1'h0);
    endtask : t_write

    task automatic t_disabled();
        u_dpsc_host.idle_clocks(20);
        @(posedge clk);
        #2 check_applied(1'h0);
    endtask : t_disabled

    task automatic t_counts();
        frame(34'h0_0013, 5, 1'h1, 1'h1);
        frame({mk(1'h0, 8'h5A, 8'hC3), mk(1'h1, 8'h11, 8'h22)}, 34, 1'h1, 1'h0);
    endtask : t_counts

    task automatic t_readback();
        logic [16:0] w;
        w = app_word;
        frame(34'h0_0000, 17, 1'h0, 1'h0);
        chk("readback pot0", field(w, 9), pot0);
        chk("readback pot1", field(w, 1), pot1);
        chk("readback stack", w[0], stack);
    endtask : t_readback

    initial begin
        clk = 1'h0;
        rst = 1'h0;
        n_mismatch = 0;
        samples_checked = 0;
        exp_word = 17'h0_0000;
        app_word = 17'h0_0000;
        #2 rst = 1'h1; // Real edge, so the stopped serial clock domain resets too
        repeat (8) @(posedge clk);
        #2 rst = 1'h0;
        repeat (3) @(posedge clk);
        #2 check_applied(1'h0);
        t_write();
        t_disabled();
        t_counts();
        t_readback();
        final_report();
    end
endmodule : dpsc_top_tb
`default_nettype wire
